// file: mem_instr_pkg.sv
// Shared constants and types of the memory-side instruction unit.
// Assumes a single core clock and an APB register port with 32-bit data.
package mem_instr_pkg;

    // =========================================================================
    // Register map
    localparam logic [11:0] ADDR_CTRL       = 12'h000;
    localparam logic [11:0] ADDR_STATUS     = 12'h004;
    localparam int          CTRL_PREFETCH_INSTR_EN    = 0;
    localparam int          CTRL_ERR_REPORT = 1;
    localparam logic [1:0]  CTRL_RESET      = 2'h1;
    localparam int          STAT_LINK       = 0;
    localparam int          STAT_BUSY       = 1;
    localparam int          STAT_EXC_LSB    = 4;

    // =========================================================================
    // Prefetch hints
    localparam logic [4:0] HINT_LOAD           = 5'h00;
    localparam logic [4:0] HINT_STORE          = 5'h01;
    localparam logic [4:0] HINT_LOAD_STREAMED  = 5'h04;
    localparam logic [4:0] HINT_STORE_STREAMED = 5'h05;
    localparam logic [4:0] HINT_LOAD_RETAINED  = 5'h06;
    localparam logic [4:0] HINT_STORE_RETAINED = 5'h07;
    localparam logic [4:0] HINT_WB_INVALIDATE  = 5'h19;

    // =========================================================================
    // Operation kinds and exception codes
    localparam logic [1:0] UNUSABLE_COP = 2'h0;
    localparam int         CCA_W        = 3;

    typedef enum logic [1:0] {OP_CACHE, OP_LL, OP_PREFETCH_INSTR} op_e;

    typedef enum logic [3:0] {
        EXC_NONE,
        EXC_TLB_REFILL,
        EXC_TLB_INVALID,
        EXC_ADDR_ERR,
        EXC_RESERVED,
        EXC_WATCH,
        EXC_COP_UNUSABLE,
        EXC_BUS_ERR,
        EXC_CACHE_ERR
    } exc_e;

endpackage

// file: agu_if.sv
// Address and hint signals between the unit and its decoder.
// Assumes the decoder is purely combinational.
`timescale 1ns/100ps
interface agu_if;
    logic [31:0] base;
    logic [15:0] offset;
    logic [4:0]  hint;
    logic [31:0] ea;
    logic        misaligned;
    logic        hint_fetch;
    logic        hint_store;
    logic        hint_stream;
    logic        hint_retain;
    logic        hint_wbinv;
    logic        hint_nop;
    modport agu  (input base, offset, hint,
                  output ea, misaligned, hint_fetch, hint_store, hint_stream,
                  hint_retain, hint_wbinv, hint_nop);
    modport user (output base, offset, hint,
                  input ea, misaligned, hint_fetch, hint_store, hint_stream,
                  hint_retain, hint_wbinv, hint_nop);
endinterface

// file: addr_hint_decode.sv
// Effective address former and prefetch hint decoder.
// Assumes inputs are stable for the cycle in which they are used.
`timescale 1ns/100ps
module addr_hint_decode
(
    agu_if.agu a
);
    // =========================================================================
    // Address formation
    assign a.ea         = a.base + {{16{a.offset[15]}}, a.offset};
    assign a.misaligned = |a.ea[1:0];

    // =========================================================================
    // Hint classes
    wire is_load   = a.hint == mem_instr_pkg::HINT_LOAD;
    wire is_store  = a.hint == mem_instr_pkg::HINT_STORE;
    wire ld_stream = a.hint == mem_instr_pkg::HINT_LOAD_STREAMED;
    wire st_stream = a.hint == mem_instr_pkg::HINT_STORE_STREAMED;
    wire ld_retain = a.hint == mem_instr_pkg::HINT_LOAD_RETAINED;
    wire st_retain = a.hint == mem_instr_pkg::HINT_STORE_RETAINED;

    assign a.hint_stream = ld_stream | st_stream;
    assign a.hint_retain = ld_retain | st_retain;
    assign a.hint_store  = is_store | st_stream | st_retain;
    assign a.hint_fetch  = is_load | is_store | a.hint_stream | a.hint_retain;
    assign a.hint_wbinv  = a.hint == mem_instr_pkg::HINT_WB_INVALIDATE;
    // Reserved values and the unsupported prepare-for-store hint do nothing.
    assign a.hint_nop    = ~(a.hint_fetch | a.hint_wbinv);
endmodule // addr_hint_decode

// file: mem_instr_unit.sv
// Execution of cache maintenance, linked load and prefetch instructions.
// Assumes translation, cache lookup and bus read are answered by outside logic.
`timescale 1ns/100ps
module mem_instr_unit
#(
    parameter int ADDR_W = 12
)
(
    input  wire logic                         pclk,
    input  wire logic                         presetn,
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [ADDR_W-1:0]            paddr,
    input  wire logic [31:0]                  pwdata,
    input  wire logic [3:0]                   pstrb,
    output logic      [31:0]                  prdata,
    output logic                              pready,
    output logic                              pslverr,
    input  wire logic                         issue_valid,
    input  wire mem_instr_pkg::op_e           issue_kind,
    input  wire logic [31:0]                  issue_base,
    input  wire logic [15:0]                  issue_offset,
    input  wire logic [4:0]                   issue_field,
    input  wire logic [4:0]                   issue_target_gpr,
    input  wire logic                         issue_reserved,
    input  wire logic                         cp0_usable,
    input  wire logic                         eret,
    output logic                              instr_ready,
    output logic                              xl_req,
    output logic      [31:0]                  xl_vaddr,
    input  wire logic                         xl_ack,
    input  wire logic [31:0]                  xl_paddr,
    input  wire logic [mem_instr_pkg::CCA_W-1:0] xl_cca,
    input  wire logic                         xl_uncached,
    input  wire logic                         xl_refill,
    input  wire logic                         xl_invalid,
    input  wire logic                         xl_addr_err,
    input  wire logic                         xl_watch,
    input  wire logic                         line_hit,
    input  wire logic                         line_dirty,
    input  wire logic                         line_locked,
    output logic                              rd_req,
    output logic      [31:0]                  mem_addr,
    output logic      [mem_instr_pkg::CCA_W-1:0] rd_cca,
    output logic                              rd_prefetch,
    output logic                              rd_store_intent,
    output logic                              rd_streamed,
    output logic                              rd_retained,
    input  wire logic                         rd_ack,
    input  wire logic [31:0]                  rd_data,
    input  wire logic                         rd_err,
    output logic                              wbinv_req,
    output logic                              cop_req,
    output logic      [4:0]                   cop_op,
    input  wire logic                         bus_err_in,
    input  wire logic                         cache_err_in,
    input  wire logic                         err_from_prefetch_instr,
    output logic                              gpr_we,
    output logic      [4:0]                   gpr_idx,
    output logic      [31:0]                  gpr_wdata,
    output logic                              link_flag,
    output logic                              exc_valid,
    output mem_instr_pkg::exc_e               exc_code,
    output logic      [1:0]                   exc_cop
);
    typedef enum logic [1:0] {S_IDLE, S_XLATE, S_LOAD} state_e;

    state_e              state_q;
    state_e              state_d;
    mem_instr_pkg::op_e  kind_q;
    mem_instr_pkg::exc_e exc_d;
    mem_instr_pkg::exc_e last_exc_q;
    logic [4:0]          field_q;
    logic [4:0]          rt_q;
    logic [1:0]          ctrl_q;
    logic                pready_q;
    logic [31:0]         prdata_q;
    logic                pslverr_q;
    logic                ready_q;
    logic                xl_req_q;
    logic [31:0]         xl_vaddr_q;
    logic                rd_req_q;
    logic [31:0]         mem_addr_q;
    logic [2:0]          rd_cca_q;
    logic [3:0]          rd_kind_q;
    logic                wbinv_q;
    logic                cop_req_q;
    logic                gpr_we_q;
    logic [31:0]         gpr_wdata_q;
    logic                link_q;
    logic                exc_valid_q;
    mem_instr_pkg::exc_e exc_code_q;
    logic [1:0]          exc_cop_q;

    agu_if ag ();

    addr_hint_decode u_decode
    (
        .a (ag)
    );

    assign ag.base   = issue_base;
    assign ag.offset = issue_offset;
    assign ag.hint   = field_q;

    // =========================================================================
    // APB slave: two-cycle access phase, unmapped addresses answer with error
    wire        apb_acc  = psel & penable & ~pready_q;
    wire        apb_wr   = psel & penable & pready_q & pwrite;
    wire        sel_ctrl = paddr == ADDR_W'(mem_instr_pkg::ADDR_CTRL);
    wire        sel_stat = paddr == ADDR_W'(mem_instr_pkg::ADDR_STATUS);
    wire [31:0] stat_val = {24'h000000, last_exc_q, 2'h0, ~ready_q, link_q};
    wire [31:0] rd_mux   = sel_ctrl ? {30'h0, ctrl_q}
                         : sel_stat ? stat_val : 32'h00000000;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q  <= 1'b0;
            prdata_q  <= 32'h00000000;
            pslverr_q <= 1'b0;
        end
        else
        begin
            pready_q  <= apb_acc;
            prdata_q  <= (apb_acc & ~pwrite) ? rd_mux : 32'h00000000;
            pslverr_q <= apb_acc & ~(sel_ctrl | sel_stat);
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl_q <= mem_instr_pkg::CTRL_RESET;
        else if (apb_wr & sel_ctrl & pstrb[0])
            ctrl_q <= pwdata[1:0];
    end

    // =========================================================================
    // Issue decode
    wire take     = issue_valid & ready_q;
    wire cp_fault = take & (issue_kind == mem_instr_pkg::OP_CACHE) & ~cp0_usable;
    wire ll_issue = take & (issue_kind == mem_instr_pkg::OP_LL);
    wire ri_fault = ll_issue & issue_reserved;
    wire al_fault = ll_issue & ~issue_reserved & ag.misaligned;
    wire go_xl    = take & ~cp_fault & ~ri_fault & ~al_fault;

    // =========================================================================
    // Translation answer handling
    wire ack      = (state_q == S_XLATE) & xl_ack;
    wire tr_fault = xl_refill | xl_invalid | xl_addr_err;
    wire is_pf    = kind_q == mem_instr_pkg::OP_PREFETCH_INSTR;
    wire is_ll    = kind_q == mem_instr_pkg::OP_LL;
    wire is_co    = kind_q == mem_instr_pkg::OP_CACHE;
    // A faulting or uncached prefetch is dropped silently.
    wire pf_ok    = ack & is_pf & ctrl_q[mem_instr_pkg::CTRL_PREFETCH_INSTR_EN] & ~tr_fault
                  & ~xl_uncached & ~ag.hint_nop & ~(line_hit & line_locked);
    wire pf_fetch = pf_ok & ag.hint_fetch;
    wire pf_wbinv = pf_ok & ag.hint_wbinv & line_hit & line_dirty;
    wire ll_go    = ack & is_ll & ~tr_fault & ~xl_watch;
    wire co_go    = ack & is_co & ~tr_fault;
    wire ld_done  = (state_q == S_LOAD) & rd_ack;
    wire err_rep  = ctrl_q[mem_instr_pkg::CTRL_ERR_REPORT] | ~err_from_prefetch_instr;

    always_comb
    begin
        exc_d = mem_instr_pkg::EXC_NONE;
        if (cp_fault)
            exc_d = mem_instr_pkg::EXC_COP_UNUSABLE;
        else if (ri_fault)
            exc_d = mem_instr_pkg::EXC_RESERVED;
        else if (al_fault)
            exc_d = mem_instr_pkg::EXC_ADDR_ERR;
        else if (ack & ~is_pf & xl_refill)
            exc_d = mem_instr_pkg::EXC_TLB_REFILL;
        else if (ack & ~is_pf & xl_invalid)
            exc_d = mem_instr_pkg::EXC_TLB_INVALID;
        else if (ack & ~is_pf & xl_addr_err)
            exc_d = mem_instr_pkg::EXC_ADDR_ERR;
        else if (ack & is_ll & xl_watch)
            exc_d = mem_instr_pkg::EXC_WATCH;
        else if (ld_done & rd_err)
            exc_d = mem_instr_pkg::EXC_BUS_ERR;
        else if (bus_err_in & err_rep)
            exc_d = mem_instr_pkg::EXC_BUS_ERR;
        else if (cache_err_in & err_rep)
            exc_d = mem_instr_pkg::EXC_CACHE_ERR;
    end

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            S_IDLE:  if (go_xl) state_d = S_XLATE;
            S_XLATE: if (ack) state_d = ll_go ? S_LOAD : S_IDLE;
            S_LOAD:  if (rd_ack) state_d = S_IDLE;
            default: state_d = S_IDLE;
        endcase
    end

    // =========================================================================
    // Sequencer registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q    <= S_IDLE;
            ready_q    <= 1'b0;
            kind_q     <= mem_instr_pkg::OP_CACHE;
            field_q    <= 5'h00;
            rt_q       <= 5'h00;
            xl_req_q   <= 1'b0;
            xl_vaddr_q <= 32'h00000000;
        end
        else
        begin
            state_q  <= state_d;
            ready_q  <= state_d == S_IDLE;
            xl_req_q <= go_xl;
            if (go_xl)
            begin
                kind_q     <= issue_kind;
                field_q    <= issue_field;
                rt_q       <= issue_target_gpr;
                xl_vaddr_q <= ag.ea;
            end
        end
    end

    // =========================================================================
    // Memory and cache requests
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rd_req_q   <= 1'b0;
            mem_addr_q <= 32'h00000000;
            rd_cca_q   <= 3'h0;
            rd_kind_q  <= 4'h0;
            wbinv_q    <= 1'b0;
            cop_req_q  <= 1'b0;
        end
        else
        begin
            // The linked load is a plain read: no snoop or invalidate goes out.
            rd_req_q  <= ll_go | pf_fetch;
            wbinv_q   <= pf_wbinv;
            cop_req_q <= co_go;
            if (ack)
            begin
                mem_addr_q <= {xl_paddr[31:2], 2'h0};
                rd_cca_q   <= xl_cca;
                rd_kind_q  <= {pf_fetch, pf_fetch & ag.hint_store,
                               pf_fetch & ag.hint_stream, pf_fetch & ag.hint_retain};
            end
        end
    end

    // =========================================================================
    // Register writeback, link flag and exceptions
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            gpr_we_q    <= 1'b0;
            gpr_wdata_q <= 32'h00000000;
            link_q      <= 1'b0;
        end
        else
        begin
            gpr_we_q <= ld_done & ~rd_err;
            if (ld_done)
                gpr_wdata_q <= rd_data;
            // A new linked load wins over a simultaneous return from exception.
            if (ld_done & ~rd_err)
                link_q <= 1'b1;
            else if (eret)
                link_q <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            exc_valid_q <= 1'b0;
            exc_code_q  <= mem_instr_pkg::EXC_NONE;
            exc_cop_q   <= 2'h0;
            last_exc_q  <= mem_instr_pkg::EXC_NONE;
        end
        else
        begin
            exc_valid_q <= exc_d != mem_instr_pkg::EXC_NONE;
            exc_code_q  <= exc_d;
            exc_cop_q   <= mem_instr_pkg::UNUSABLE_COP;
            if (exc_d != mem_instr_pkg::EXC_NONE)
                last_exc_q <= exc_d;
        end
    end

    // =========================================================================
    // Outputs
    assign prdata          = prdata_q;
    assign pready          = pready_q;
    assign pslverr         = pslverr_q;
    assign instr_ready     = ready_q;
    assign xl_req          = xl_req_q;
    assign xl_vaddr        = xl_vaddr_q;
    assign rd_req          = rd_req_q;
    assign mem_addr        = mem_addr_q;
    assign rd_cca          = rd_cca_q;
    assign rd_prefetch     = rd_kind_q[3];
    assign rd_store_intent = rd_kind_q[2];
    assign rd_streamed     = rd_kind_q[1];
    assign rd_retained     = rd_kind_q[0];
    assign wbinv_req       = wbinv_q;
    assign cop_req         = cop_req_q;
    assign cop_op          = field_q;
    assign gpr_we          = gpr_we_q;
    assign gpr_idx         = rt_q;
    assign gpr_wdata       = gpr_wdata_q;
    assign link_flag       = link_q;
    assign exc_valid       = exc_valid_q;
    assign exc_code        = exc_code_q;
    assign exc_cop         = exc_cop_q;

    // =========================================================================
    // Assertions
    cop_unusable_a: assert property (@(posedge pclk) disable iff (!presetn)
        cp_fault |=> exc_valid && exc_code == mem_instr_pkg::EXC_COP_UNUSABLE && !xl_req)
        else $error("cache op without coprocessor access did not fault");
    ea_form_a: assert property (@(posedge pclk) disable iff (!presetn)
        go_xl |=> xl_req && xl_vaddr == $past(issue_base) + {{16{$past(issue_offset[15])}},
                                                 $past(issue_offset)})
        else $error("effective address wrong");
    ll_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        ld_done && !rd_err |=> gpr_we && gpr_wdata == $past(rd_data) && gpr_idx == rt_q)
        else $error("linked load data not written");
    link_set_a: assert property (@(posedge pclk) disable iff (!presetn)
        ld_done && !rd_err |=> link_flag ##1 (link_flag || $past(eret)))
        else $error("link flag not set");
    ll_align_a: assert property (@(posedge pclk) disable iff (!presetn)
        al_fault |=> exc_valid && exc_code == mem_instr_pkg::EXC_ADDR_ERR && !xl_req && !rd_req)
        else $error("misaligned linked load not refused");
    prefetch_instr_noexc_a: assert property (@(posedge pclk) disable iff (!presetn)
        ack && is_pf && !bus_err_in && !cache_err_in |=> !exc_valid)
        else $error("prefetch raised an exception");
    prefetch_instr_uncached_a: assert property (@(posedge pclk) disable iff (!presetn)
        ack && is_pf && xl_uncached |=> !rd_req && !wbinv_req)
        else $error("uncached prefetch issued memory operation");
    prefetch_instr_nostall_a: assert property (@(posedge pclk) disable iff (!presetn)
        ack && is_pf |=> instr_ready && state_q == S_IDLE)
        else $error("prefetch stalled the pipeline");
    prefetch_instr_locked_a: assert property (@(posedge pclk) disable iff (!presetn)
        ack && is_pf && line_hit && line_locked |=> !rd_req && !wbinv_req)
        else $error("prefetch touched a locked line");

endmodule // mem_instr_unit

// file: mem_side_model.sv
// Behavioural translation, cache-state and bus-read responder.
// Assumes the unit's requests are one-cycle pulses.
`timescale 1ns/100ps
module mem_side_model
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        xl_req,
    input  wire logic [31:0] xl_vaddr,
    input  wire logic        rd_req,
    input  wire logic [31:0] mem_addr,
    input  wire logic [7:0]  cfg,
    input  wire logic [3:0]  lat,
    output logic             xl_ack,
    output logic [31:0]      xl_paddr,
    output logic [10:0]      xl_info,
    output logic             rd_ack,
    output logic [32:0]      rd_bus
);
    logic [4:0]  left_q;
    logic [10:0] info;
    logic [31:0] pa;
    logic [32:0] word;
    assign pa = xl_vaddr ^ 32'hA000_0000;
    assign info = {3'h5, cfg[0], cfg[2:1] == 2'h1, cfg[2:1] == 2'h2, cfg[2:1] == 2'h3,
                   cfg[3], 1'b1, cfg[5], cfg[4]};
    assign word = {cfg[6], mem_addr ^ 32'h5A5A_0000};
    // Released lines carry the inverse, so a stale value never passes as an answer.
    assign xl_paddr = xl_ack ? pa : ~pa;
    assign xl_info  = xl_ack ? info : ~info;
    assign rd_bus   = rd_ack ? word : ~word;
    always @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            xl_ack <= 1'b0;
            rd_ack <= 1'b0;
            left_q <= 5'h00;
        end
        else
        begin
            xl_ack <= xl_req;
            rd_ack <= left_q == 5'h01;
            if (rd_req)
                left_q <= {1'b0, lat} + 5'h02;
            else if (left_q != 5'h00)
                left_q <= left_q - 5'h01;
        end
endmodule // mem_side_model

// file: cache_prefetch_linked_load_tb.sv
// Self-checking bench of the memory-side instruction unit.
// Assumes mem_side_model stands for translation, cache and bus.
`timescale 1ns/100ps
module cache_prefetch_linked_load_tb;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, issue_valid = 0;
    logic issue_reserved = 0, cp0_usable = 1, eret = 0, bus_err_in = 0, cache_err_in = 0;
    logic err_from_prefetch_instr = 1, pready, pslverr, instr_ready, xl_req, xl_ack, rd_req, rd_ack;
    logic line_hit, line_dirty, line_locked, xl_uncached, xl_refill, xl_invalid, xl_addr_err;
    logic xl_watch, rd_err, rd_prefetch, rd_store_intent, rd_streamed, rd_retained, wbinv_req;
    logic cop_req, gpr_we, link_flag, exc_valid, e;
    logic [1:0] exc_cop;
    logic [2:0] xl_cca, rd_cca;
    logic [3:0] pstrb = 4'hF, lat = 4'h0;
    logic [4:0] issue_field = 0, issue_target_gpr = 0, cop_op, gpr_idx;
    logic [5:0] ev, ex_q;
    logic [6:0] rf_q;
    logic [7:0] cfg = 8'h20;
    logic [10:0] xl_info;
    logic [11:0] paddr = 0;
    logic [15:0] issue_offset = 0;
    logic [31:0] pwdata = 0, prdata, xl_vaddr, xl_paddr, mem_addr, rd_data, gpr_wdata, r, ma_q;
    logic [31:0] issue_base = 0;
    logic [32:0] rd_bus;
    logic [36:0] gw_q;
    mem_instr_pkg::op_e issue_kind = mem_instr_pkg::OP_PREFETCH_INSTR;
    mem_instr_pkg::exc_e exc_code;
    int err_total = 0, n_checks = 0, cyc, n[6];
    mem_instr_unit i_dut (.*);
    mem_side_model i_mem (.*);
    assign {xl_cca, xl_uncached, xl_refill, xl_invalid, xl_addr_err, xl_watch, line_hit,
            line_dirty, line_locked} = xl_info;
    assign {rd_err, rd_data} = rd_bus;
    assign ev = {xl_req, rd_req, wbinv_req, cop_req, exc_valid, gpr_we};
    always #25 pclk = ~pclk;
    always @(posedge pclk)
    begin
        foreach (n[i]) n[i] <= n[i] + int'(ev[i]);
        if (exc_valid) ex_q <= {exc_code, exc_cop};
        if (rd_req | cop_req | wbinv_req) ma_q <= mem_addr;
        if (rd_req) rf_q <= {rd_prefetch, rd_store_intent, rd_streamed, rd_retained, rd_cca};
        if (gpr_we) gw_q <= {gpr_idx, gpr_wdata};
    end
    task automatic chk(input string nm, input logic [36:0] seen, input logic [36:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic chk_ev(input string nm, input logic [5:0] exp);
        for (int i = 0; i < 6; i++) chk(nm, 37'(n[i]), {36'h0, exp[i]});
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i = 0;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1 && ++i < 50);
        if (i >= 50) err_total++;
        {r, e} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
    endtask
    task automatic op(input mem_instr_pkg::op_e k, input logic [31:0] b, input logic [4:0] f);
        @(negedge pclk);
        n = '{default: 0};
        @(posedge pclk);
        issue_valid <= 1'b1;
        issue_kind  <= k;
        {issue_base, issue_offset, issue_field} <= {b, 16'hFFF8, f};
        @(posedge pclk);
        issue_valid <= 1'b0;
        cyc = 0;
        do @(posedge pclk); while (instr_ready !== 1'b1 && ++cyc < 300);
        if (cyc >= 300) err_total++;
        repeat (3) @(posedge pclk);
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial
    begin
        #250000;
        err_total++;
        give_verdict();
    end
    // =====================================================================
    // Main sequence
    initial
    begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        apb(0, 12'h000, 0);
        chk("ctrl", r, 1);
        apb(0, 12'h008, 0);
        chk("unmapped", e, 1);
        pstrb <= 4'hE;
        apb(1, 12'h000, 0);
        pstrb <= 4'hF;
        apb(0, 12'h000, 0);
        chk("strb", r, 1);
        apb(1, 12'h000, 0);
        op(mem_instr_pkg::OP_PREFETCH_INSTR, 32'h2000_0058, 0);
        chk("off", n[4], 0);
        apb(1, 12'h000, 1);
        $display("test registers done");
        for (int h = 0; h < 32; h++)
        begin
            e = h < 2 || (h > 3 && h < 8);
            op(mem_instr_pkg::OP_PREFETCH_INSTR, 32'h2000_0058, h[4:0]);
            chk_ev("hint", {1'b1, e, h == 25, 3'b000});
            if (e) chk("flags", rf_q, {1'b1, h[0], h[2:1] == 2, h > 5, 3'h5});
            if (e) chk("addr", ma_q, 32'h8000_0050);
        end
        for (int k = 0; k < 8; k++)
        begin
            cfg <= {2'b00, k != 7, k == 5 || k == 6, 1'b0,
                    (k > 1 && k < 5) ? 2'(k - 1) : 2'h0, k < 2};
            op(mem_instr_pkg::OP_PREFETCH_INSTR, 32'h2000_0058, (k == 1 || k > 5) ? 5'h19 : 5'h00);
            chk_ev("drop", 6'b100000);
        end
        $display("test prefetch done");
        {cfg, lat, issue_target_gpr} <= {8'h20, 4'h6, 5'h09};
        op(mem_instr_pkg::OP_LL, 32'h1000_0100, 0);
        chk("ll_va", xl_vaddr, 32'h1000_00F8);
        chk_ev("ll", 6'b110001);
        chk("ll_wr", gw_q, {5'h09, 32'hEA5A_00F8});
        chk("link", link_flag, 1);
        for (int k = 0; k < 6; k++)
        begin
            issue_reserved <= k == 1;
            cfg <= {4'h2, k == 5, (k > 1 && k < 5) ? 2'(k - 1) : 2'h0, 1'b0};
            op(mem_instr_pkg::OP_LL, 32'h1000_0100 + (k == 0 ? 2 : 0), 0);
            chk_ev("ll_fault", {k > 1, 5'b00010});
            chk("ll_code", ex_q[5:2], k < 2 ? 3 + k : k == 5 ? 5 : k - 1);
        end
        @(posedge pclk) {issue_reserved, eret, cfg} <= {2'b01, 8'h60};
        @(posedge pclk) eret <= 1'b0;
        op(mem_instr_pkg::OP_LL, 32'h1000_0100, 0);
        chk("ll_err", {ex_q, link_flag, n[0] != 0}, {mem_instr_pkg::EXC_BUS_ERR, 4'h0});
        apb(0, 12'h004, 0);
        chk("status", r, 32'h70);
        $display("test linked load done");
        {cp0_usable, cfg} <= {1'b0, 8'h20};
        op(mem_instr_pkg::OP_CACHE, 32'h0000_0410, 5'h15);
        chk_ev("cop_off", 6'b000010);
        chk("cop_exc", ex_q, {mem_instr_pkg::EXC_COP_UNUSABLE, 2'b00});
        cp0_usable <= 1'b1;
        op(mem_instr_pkg::OP_CACHE, 32'h0000_0410, 5'h15);
        chk_ev("cop", 6'b100100);
        chk("cop_at", {cop_op, ma_q}, {5'h15, 32'hA000_0408});
        chk("cop_va", xl_vaddr, 32'h0000_0408);
        for (int j = 0; j < 6; j++)
        begin
            apb(1, 12'h000, {30'h0, j[1], 1'b1});
            err_from_prefetch_instr <= j < 4;
            @(negedge pclk) n[1] = 0;
            @(posedge pclk) {cache_err_in, bus_err_in} <= {j[0], ~j[0]};
            @(posedge pclk) {cache_err_in, bus_err_in} <= 2'b00;
            repeat (3) @(posedge pclk);
            chk("prefetch_instr_err", n[1], j[1] || j > 3);
            if (j[1] || j > 3) chk("err_code", ex_q[5:2], j[0] ? 4'h8 : 4'h7);
        end
        lat <= 4'hF;
        op(mem_instr_pkg::OP_PREFETCH_INSTR, 32'h2000_0058, 5'h00);
        chk("nonblock", cyc < 8, 1);
        repeat (20) @(posedge pclk);
        $display("test cache and errors done");
        give_verdict();
    end
endmodule // cache_prefetch_linked_load_tb
